//--- design/lane_eq_select_registers.sv
/*
 * equalizer selection register bank for three receive lanes, programmed
 * through a two-wire serial slave, with the applied gain code and boost.
 * assumes training level, sink select and rate come from core logic on
 * clk_sys_i; serial pins and gain pins are asynchronous and are filtered.
 */
// Contract
// - trained DP with register control: use trained level
// - levels 0 and 2 in bits 6:4
// - levels 1 and 3 in bits 2:0
// - training off on DP: level-1 code fixed
// - TMDS sink: level-1 code fixed always
// - every gain field resets to zero boost
// - codes 1..3 decode by link rate
// - codes 4..7 decode by link rate
// - bit 7 picks pins or registers, default pins
// - training enable defaults on, off fixes gain
`timescale 1ns/1ps
module lane_eq_select_registers (
	input  wire logic       clk_sys_i,             // core clock, 10 MHz
	input  wire logic       rstn_i,                // async reset, active low
	input  wire logic       scl_i,                 // serial clock pin
	input  wire logic       sda_i,                 // serial data pin level
	output logic            sda_o,                 // level driven when enabled
	output logic            sda_oe_n_o,            // low while pulling data low
	input  wire logic [2:0] pin_gain_code_i,       // gain strap pins
	input  wire logic       dp_sink_sel_i,         // 1 dp sink, 0 tmds sink
	input  wire logic [1:0] train_level_i,         // pre-emphasis reached
	input  wire logic       hbr2_rate_i,           // 1 at the higher rate
	output logic [eq_sel_pkg::NUM_LANES-1:0][2:0] lane_gain_code_o,
	output logic [eq_sel_pkg::NUM_LANES-1:0][7:0] lane_boost_tenth_db_o,
	output logic            register_gain_control_on_o,
	output logic            link_training_on_o
);

	// ------------------------------------------------------------------
	// pin filtering: three flops, a change counts once the last two agree
	// ------------------------------------------------------------------
	eq_sel_pkg::pin_bus_t pin_s1_q, pin_s2_q, pin_s3_q; // raw sampling chain
	eq_sel_pkg::pin_bus_t pin_f_q, pin_f_d;             // filtered level
	eq_sel_pkg::pin_bus_t pin_p_q;                      // filtered, one cycle late
	logic                 scl_rise, scl_fall, start_c, stop_c;

	// per-bit update only where stage two and three agree
	always_comb begin
		pin_f_d = (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_s1_q <= eq_sel_pkg::PIN_IDLE;
			pin_s2_q <= eq_sel_pkg::PIN_IDLE;
			pin_s3_q <= eq_sel_pkg::PIN_IDLE;
			pin_f_q  <= eq_sel_pkg::PIN_IDLE;
			pin_p_q  <= eq_sel_pkg::PIN_IDLE;
		end else begin
			pin_s1_q <= {pin_gain_code_i, sda_i, scl_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_f_q  <= pin_f_d;
			pin_p_q  <= pin_f_q;
		end
	end

	// bus events from the filtered levels only
	assign scl_rise = pin_f_q.scl & ~pin_p_q.scl;
	assign scl_fall = ~pin_f_q.scl & pin_p_q.scl;
	assign start_c  = pin_f_q.scl & pin_p_q.scl & pin_p_q.sda & ~pin_f_q.sda;
	assign stop_c   = pin_f_q.scl & pin_p_q.scl & ~pin_p_q.sda & pin_f_q.sda;

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	logic                   train_en_q, train_en_d;   // training enable
	logic                   regctl_q, regctl_d;       // register source select
	eq_sel_pkg::lane_gain_t gains_q [eq_sel_pkg::NUM_LANES];
	eq_sel_pkg::lane_gain_t gains_d [eq_sel_pkg::NUM_LANES];
	logic [7:0]             rd_byte;                  // read view at pointer
	logic                   wr_stb;                   // one-cycle write strobe
	logic [7:0]             ptr_q, ptr_d;             // register pointer
	logic [7:0]             shift_q, shift_d;         // serial shift register

	// writes land only on defined field bits; bits 7 and 3 of lane
	// registers are not stored and read back zero, except bit 7 of lane 0 lower (source select)
	always_comb begin
		train_en_d = train_en_q;
		regctl_d   = regctl_q;
		gains_d    = gains_q;
		if (wr_stb) begin
			if (ptr_q == eq_sel_pkg::OFS_TRAIN_CTL)
				train_en_d = shift_q[eq_sel_pkg::TRAIN_EN_BIT];
			if (ptr_q == eq_sel_pkg::OFS_LANE0_LOWER)
				regctl_d = shift_q[eq_sel_pkg::REGCTL_BIT];
			for (int l = 0; l < eq_sel_pkg::NUM_LANES; l++) begin
				if (ptr_q == 8'(int'(eq_sel_pkg::OFS_LANE0_LOWER) +
				    eq_sel_pkg::OFS_LANE_STRIDE * l)) begin
					gains_d[l].level0 = shift_q[eq_sel_pkg::HI_FIELD_LSB +: 3];
					gains_d[l].level1 = shift_q[eq_sel_pkg::LO_FIELD_LSB +: 3];
				end
				if (l < eq_sel_pkg::NUM_UPPER_LANES &&
				    ptr_q == 8'(int'(eq_sel_pkg::OFS_LANE0_UPPER) +
				    eq_sel_pkg::OFS_LANE_STRIDE * l)) begin
					gains_d[l].level2 = shift_q[eq_sel_pkg::HI_FIELD_LSB +: 3];
					gains_d[l].level3 = shift_q[eq_sel_pkg::LO_FIELD_LSB +: 3];
				end
			end
		end
	end

	// read view; unmapped addresses and reserved bits read zero
	always_comb begin
		rd_byte = 8'h00;
		if (ptr_q == eq_sel_pkg::OFS_TRAIN_CTL)
			rd_byte[eq_sel_pkg::TRAIN_EN_BIT] = train_en_q;
		for (int l = 0; l < eq_sel_pkg::NUM_LANES; l++) begin
			if (ptr_q == 8'(int'(eq_sel_pkg::OFS_LANE0_LOWER) +
			    eq_sel_pkg::OFS_LANE_STRIDE * l)) begin
				rd_byte = {1'b0, gains_q[l].level0, 1'b0, gains_q[l].level1};
				if (l == 0)
					rd_byte[eq_sel_pkg::REGCTL_BIT] = regctl_q;
			end
			if (l < eq_sel_pkg::NUM_UPPER_LANES &&
			    ptr_q == 8'(int'(eq_sel_pkg::OFS_LANE0_UPPER) +
			    eq_sel_pkg::OFS_LANE_STRIDE * l))
				rd_byte = {1'b0, gains_q[l].level2, 1'b0, gains_q[l].level3};
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			train_en_q <= eq_sel_pkg::TRAIN_EN_RST;
			regctl_q   <= eq_sel_pkg::REGCTL_RST;
			for (int l = 0; l < eq_sel_pkg::NUM_LANES; l++)
				gains_q[l] <= {4{eq_sel_pkg::GAIN_RST}};
		end else begin
			train_en_q <= train_en_d;
			regctl_q   <= regctl_d;
			gains_q    <= gains_d;
		end
	end

	// ------------------------------------------------------------------
	// serial slave: address, pointer, then data with auto-increment
	// ------------------------------------------------------------------
	eq_sel_pkg::port_state_t st_q, st_d;           // current phase
	eq_sel_pkg::port_state_t ack_next_q, ack_next_d; // phase after our ack
	logic [3:0]              bit_cnt_q, bit_cnt_d;  // bits seen in byte
	logic                    sda_oe_n_q, sda_oe_n_d; // low pulls data low

	// data only changes after a falling clock, so the master samples it clean
	always_comb begin
		st_d       = st_q;
		ack_next_d = ack_next_q;
		bit_cnt_d  = bit_cnt_q;
		shift_d    = shift_q;
		ptr_d      = ptr_q;
		sda_oe_n_d = sda_oe_n_q;
		wr_stb     = 1'b0;
		if (start_c) begin
			st_d       = eq_sel_pkg::S_ADDR;
			bit_cnt_d  = 4'h0;
			sda_oe_n_d = 1'b1;
		end else if (stop_c) begin
			st_d       = eq_sel_pkg::S_IDLE;
			sda_oe_n_d = 1'b1;
		end else begin
			case (st_q)
				eq_sel_pkg::S_ADDR, eq_sel_pkg::S_PTR, eq_sel_pkg::S_WDATA: begin
					if (scl_rise) begin
						shift_d   = {shift_q[6:0], pin_f_q.sda};
						bit_cnt_d = bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == eq_sel_pkg::BITS_PER_BYTE) begin
						bit_cnt_d  = 4'h0;
						st_d       = eq_sel_pkg::S_ACK;
						sda_oe_n_d = 1'b0;
						if (st_q == eq_sel_pkg::S_ADDR) begin
							// another address: stay silent until next start
							if (shift_q[7:1] != eq_sel_pkg::DEV_ADDR) begin
								st_d       = eq_sel_pkg::S_IDLE;
								sda_oe_n_d = 1'b1;
							end else if (shift_q[0])
								ack_next_d = eq_sel_pkg::S_RDATA;
							else
								ack_next_d = eq_sel_pkg::S_PTR;
						end else if (st_q == eq_sel_pkg::S_PTR) begin
							ptr_d      = shift_q;
							ack_next_d = eq_sel_pkg::S_WDATA;
						end else begin
							wr_stb     = 1'b1;
							ptr_d      = ptr_q + 8'h01;
							ack_next_d = eq_sel_pkg::S_WDATA;
						end
					end
				end
				eq_sel_pkg::S_ACK: begin
					if (scl_fall) begin
						st_d       = ack_next_q;
						sda_oe_n_d = 1'b1;
						if (ack_next_q == eq_sel_pkg::S_RDATA) begin
							shift_d    = rd_byte;
							ptr_d      = ptr_q + 8'h01;
							sda_oe_n_d = rd_byte[7];
						end
					end
				end
				eq_sel_pkg::S_RDATA: begin
					if (scl_rise)
						bit_cnt_d = bit_cnt_q + 4'h1;
					else if (scl_fall) begin
						if (bit_cnt_q == eq_sel_pkg::BITS_PER_BYTE) begin
							st_d       = eq_sel_pkg::S_RACK;
							bit_cnt_d  = 4'h0;
							sda_oe_n_d = 1'b1;
						end else begin
							shift_d    = {shift_q[6:0], 1'b0};
							sda_oe_n_d = shift_q[6];
						end
					end
				end
				eq_sel_pkg::S_RACK: begin
					// master ack sampled into bit 0; a nack ends the read
					if (scl_rise)
						shift_d[0] = pin_f_q.sda;
					else if (scl_fall) begin
						if (shift_q[0])
							st_d = eq_sel_pkg::S_IDLE;
						else begin
							st_d       = eq_sel_pkg::S_RDATA;
							shift_d    = rd_byte;
							ptr_d      = ptr_q + 8'h01;
							sda_oe_n_d = rd_byte[7];
						end
					end
				end
				default: st_d = eq_sel_pkg::S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q       <= eq_sel_pkg::S_IDLE;
			ack_next_q <= eq_sel_pkg::S_IDLE;
			bit_cnt_q  <= 4'h0;
			shift_q    <= 8'h00;
			ptr_q      <= 8'h00;
			sda_oe_n_q <= 1'b1;
		end else begin
			st_q       <= st_d;
			ack_next_q <= ack_next_d;
			bit_cnt_q  <= bit_cnt_d;
			shift_q    <= shift_d;
			ptr_q      <= ptr_d;
			sda_oe_n_q <= sda_oe_n_d;
		end
	end

	// ------------------------------------------------------------------
	// per-lane gain selection and boost decode
	// ------------------------------------------------------------------
	logic [2:0] code_d  [eq_sel_pkg::NUM_LANES];
	logic [7:0] boost_d [eq_sel_pkg::NUM_LANES];
	logic [2:0] code_q  [eq_sel_pkg::NUM_LANES];
	logic [7:0] boost_q [eq_sel_pkg::NUM_LANES];

	for (genvar g = 0; g < eq_sel_pkg::NUM_LANES; g++) begin : g_lane
		always_comb begin
			if (!regctl_q)
				code_d[g] = pin_f_q.code;
			else if (!dp_sink_sel_i)
				code_d[g] = gains_q[g].level1;
			else if (!train_en_q)
				code_d[g] = gains_q[g].level1;
			else begin
				case (train_level_i)
					2'h0:    code_d[g] = gains_q[g].level0;
					2'h1:    code_d[g] = gains_q[g].level1;
					2'h2:    code_d[g] = gains_q[g].level2;
					default: code_d[g] = gains_q[g].level3;
				endcase
			end
			// table lookup keeps both rates in one mux per lane
			boost_d[g] = hbr2_rate_i ? eq_sel_pkg::HBR2_TENTHS[{code_d[g], 3'h0} +: 8]
			                         : eq_sel_pkg::HBR_TENTHS[{code_d[g], 3'h0} +: 8];
		end

		always_ff @(posedge clk_sys_i or negedge rstn_i) begin
			if (!rstn_i) begin
				code_q[g]  <= eq_sel_pkg::GAIN_RST;
				boost_q[g] <= 8'h00;
			end else begin
				code_q[g]  <= code_d[g];
				boost_q[g] <= boost_d[g];
			end
		end

		assign lane_gain_code_o[g]      = code_q[g];
		assign lane_boost_tenth_db_o[g] = boost_q[g];
	end

	// open-drain data only ever pulls low
	logic sda_low_q;
	logic rst_seen_q; // first cycle after reset release is still zero
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sda_low_q  <= 1'b0;
			rst_seen_q <= 1'b0;
		end else begin
			sda_low_q  <= 1'b0;
			rst_seen_q <= 1'b1;
		end
	end

	assign sda_o                      = sda_low_q;
	assign sda_oe_n_o                 = sda_oe_n_q;
	assign register_gain_control_on_o = regctl_q;
	assign link_training_on_o         = train_en_q;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	a_level0_pick: assert property (
		(regctl_q && dp_sink_sel_i && train_en_q && train_level_i == 2'h0)
		|=> lane_gain_code_o[1] == $past(gains_q[1].level0))
		else $error("level 0 code not applied");
	a_level2_pick: assert property (
		(regctl_q && dp_sink_sel_i && train_en_q && train_level_i == 2'h2)
		|=> lane_gain_code_o[0] == $past(gains_q[0].level2))
		else $error("level 2 code not applied");
	a_level3_pick: assert property (
		(regctl_q && dp_sink_sel_i && train_en_q && train_level_i == 2'h3)
		|=> lane_gain_code_o[1] == $past(gains_q[1].level3))
		else $error("level 3 code not applied");
	a_untrained_fixed: assert property (
		(regctl_q && dp_sink_sel_i && !train_en_q)
		|=> lane_gain_code_o[2] == $past(gains_q[2].level1))
		else $error("fixed level 1 code not applied without training");
	a_tmds_fixed: assert property (
		(regctl_q && !dp_sink_sel_i) |=> lane_gain_code_o[0] == $past(gains_q[0].level1))
		else $error("tmds sink not using level 1 code");
	a_reset_gain_zero: assert property (
		!rst_seen_q |-> (gains_q[0] == '0 && gains_q[1] == '0 && gains_q[2] == '0
		&& train_en_q && !regctl_q))
		else $error("reset values wrong");
	a_boost_low_code: assert property (
		(lane_gain_code_o[0] == 3'h1 && rst_seen_q)
		|-> lane_boost_tenth_db_o[0] == ($past(hbr2_rate_i) ? 8'h23 : 8'h0f))
		else $error("code 1 boost wrong");
	a_boost_top_code: assert property (
		(lane_gain_code_o[2] == 3'h7 && rst_seen_q)
		|-> lane_boost_tenth_db_o[2] == ($past(hbr2_rate_i) ? 8'hb4 : 8'h5a))
		else $error("code 7 boost wrong");
	a_pin_source: assert property (
		!regctl_q ##1 !regctl_q |-> lane_gain_code_o[1] == $past(pin_f_q.code))
		else $error("pin code not applied");
	a_reserved_zero: assert property (
		(ptr_q >= eq_sel_pkg::OFS_LANE0_LOWER && ptr_q <= eq_sel_pkg::OFS_LANE2_LOWER)
		|-> (rd_byte[eq_sel_pkg::RSVD_LO_BIT] == 1'b0 &&
		(ptr_q == eq_sel_pkg::OFS_LANE0_LOWER || rd_byte[eq_sel_pkg::RSVD_HI_BIT] == 1'b0)))
		else $error("reserved bit reads set");

endmodule

//--- design/eq_sel_pkg.sv
/*
 * shared constants and types for the lane equalizer selection register bank:
 * register offsets, field positions, reset values, boost tables, serial
 * port states and the structs that carry pin and gain groups.
 * assumes a single core clock; nothing here is timing dependent.
 */
package eq_sel_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_TRAIN_CTL   = 8'h04; // holds the training enable
	localparam logic [7:0] OFS_LANE0_LOWER = 8'h05; // also holds the source select
	localparam logic [7:0] OFS_LANE0_UPPER = 8'h06;
	localparam logic [7:0] OFS_LANE1_LOWER = 8'h07;
	localparam logic [7:0] OFS_LANE1_UPPER = 8'h08;
	localparam logic [7:0] OFS_LANE2_LOWER = 8'h09;
	localparam int         OFS_LANE_STRIDE = 2;     // lower/upper pair per lane

	// ------------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------------
	localparam int         TRAIN_EN_BIT    = 2;
	localparam int         REGCTL_BIT      = 7;
	localparam int         RSVD_HI_BIT     = 7;
	localparam int         RSVD_LO_BIT     = 3;
	localparam int         HI_FIELD_LSB    = 4;     // levels 0 and 2
	localparam int         LO_FIELD_LSB    = 0;     // levels 1 and 3
	localparam logic       TRAIN_EN_RST    = 1'b1;
	localparam logic       REGCTL_RST      = 1'b0;
	localparam logic [2:0] GAIN_RST        = 3'h0;  // zero boost
	localparam int         NUM_LANES       = 3;
	localparam int         NUM_UPPER_LANES = 2;     // lanes whose upper register is mapped

	// ------------------------------------------------------------------
	// boost per code in tenths of a dB, code 7 in the top byte
	// ------------------------------------------------------------------
	localparam logic [63:0] HBR_TENTHS  = {8'h5a, 8'h46, 8'h3c, 8'h32,
	                                       8'h28, 8'h1e, 8'h0f, 8'h00};
	localparam logic [63:0] HBR2_TENTHS = {8'hb4, 8'h96, 8'h82, 8'h64,
	                                       8'h50, 8'h3c, 8'h23, 8'h00};

	// ------------------------------------------------------------------
	// serial port
	// ------------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR      = 7'h2c; // arbitrary value
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [4:0] PIN_IDLE      = 5'h03; // clock and data idle high

	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_PTR, S_WDATA, S_ACK, S_RDATA, S_RACK
	} port_state_t;

	typedef struct packed {
		logic [2:0] code; // pin gain code
		logic       sda;
		logic       scl;
	} pin_bus_t;

	typedef struct packed {
		logic [2:0] level0;
		logic [2:0] level1;
		logic [2:0] level2;
		logic [2:0] level3;
	} lane_gain_t;

endpackage

//--- tb/i2c_host_model.sv
/*
 * two-wire host controller model that programs and reads back the lane
 * equalizer registers; byte-level tasks are called from the bench.
 * assumes a pulled-up data line and the system clock for its pacing.
 */
`timescale 1ns/1ps
module i2c_host_model (
	input  wire logic clk_sys_i,    // pacing clock
	input  wire logic dev_sda_i,    // device data drive level
	input  wire logic dev_sda_oe_n_i, // low while the device pulls data
	output logic      scl_o,        // serial clock, idles high between frames
	output logic      sda_line_o    // resolved data wire
);
	// ---------------------------------------------------------------
	// open-drain wire resolution
	// ---------------------------------------------------------------
	logic host_sda = 1'b1; // 1 = released, pull-up wins
	assign sda_line_o = dev_sda_oe_n_i ? host_sda : (host_sda & dev_sda_i);
	initial scl_o = 1'b1;

	// ten system clocks per phase keeps us above the filter minimum
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys_i);
		#10;
	endtask

	// ---------------------------------------------------------------
	// framing
	// ---------------------------------------------------------------
	task automatic start();
		host_sda = 1'b1;
		hold(10);
		scl_o = 1'b1;
		hold(10);
		host_sda = 1'b0; // data falls while clock high
		hold(10);
		scl_o = 1'b0;
		hold(2);
	endtask

	task automatic stop();
		host_sda = 1'b0;
		hold(10);
		scl_o = 1'b1;
		hold(10);
		host_sda = 1'b1; // data rises while clock high
		hold(10);
	endtask

	// send msb first, then release data and sample the device ack
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			host_sda = b[i];
			hold(10);
			scl_o = 1'b1;
			hold(10);
			scl_o = 1'b0;
		end
		host_sda = 1'b1;
		hold(10);
		scl_o = 1'b1;
		hold(5);
		ack = sda_line_o; // 0 means acknowledged
		hold(5);
		scl_o = 1'b0;
	endtask

	// receive msb first, then answer ack or nack
	task automatic recv_byte(input logic nack, output logic [7:0] b);
		host_sda = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			hold(10);
			scl_o = 1'b1;
			hold(5);
			b[i] = sda_line_o;
			hold(5);
			scl_o = 1'b0;
		end
		hold(2);
		host_sda = nack;
		hold(8);
		scl_o = 1'b1;
		hold(10);
		scl_o = 1'b0;
		hold(2);
		host_sda = 1'b1;
	endtask

	// ---------------------------------------------------------------
	// register transfers; nak collects any missing acknowledge
	// ---------------------------------------------------------------
	task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d [8],
		input int n, output logic nak);
		logic a;
		start();
		send_byte({eq_sel_pkg::DEV_ADDR, 1'b0}, nak);
		send_byte(ptr, a);
		nak = nak | a;
		for (int i = 0; i < n; i++) begin
			send_byte(d[i], a);
			nak = nak | a;
		end
		stop();
	endtask

	task automatic read_regs(input logic [7:0] ptr, input int n,
		output logic [7:0] d [8], output logic nak);
		logic a;
		start();
		send_byte({eq_sel_pkg::DEV_ADDR, 1'b0}, nak);
		send_byte(ptr, a);
		nak = nak | a;
		start(); // repeated start turns the bus round
		send_byte({eq_sel_pkg::DEV_ADDR, 1'b1}, a);
		nak = nak | a;
		for (int i = 0; i < n; i++) begin
			recv_byte(i == n - 1, d[i]);
		end
		stop();
	endtask
endmodule

//--- tb/tb_top.sv
/*
 * self-checking bench for the lane equalizer selection register bank:
 * programs registers over the serial port, sweeps sink, training, level
 * and rate, and compares applied codes and boosts with a register image.
 * assumes the host model in i2c_host_model.sv and a 10 MHz system clock.
 */
`timescale 1ns/1ps
module tb_top;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic            clk_sys_i = 1'b0;
	logic            rstn_i    = 1'b0;
	logic            scl, sda_line, dev_sda, dev_sda_oe_n;
	logic [2:0]      pin_code  = 3'h0;
	logic            dp_sel    = 1'b1;
	logic [1:0]      lvl       = 2'h0;
	logic            rate2     = 1'b0;
	logic [2:0][2:0] code_o;
	logic [2:0][7:0] boost_o;
	logic            reg_on, train_on, nak;
	int              err_count = 0;
	int              samples_checked = 0;
	logic [7:0]      shadow [4:10]; // expected register image
	logic [7:0]      d [8];
	// boost per code in tenths of a dB, one table per rate
	localparam logic [7:0] HBR_T [8]  = '{8'h00, 8'h0f, 8'h1e, 8'h28,
	                                      8'h32, 8'h3c, 8'h46, 8'h5a};
	localparam logic [7:0] HBR2_T [8] = '{8'h00, 8'h23, 8'h3c, 8'h50,
	                                      8'h64, 8'h82, 8'h96, 8'hb4};

	always #50 clk_sys_i = ~clk_sys_i;

	lane_eq_select_registers u_lane_eq_select_registers (
		.clk_sys_i                  (clk_sys_i),
		.rstn_i                     (rstn_i),
		.scl_i                      (scl),
		.sda_i                      (sda_line),
		.sda_o                      (dev_sda),
		.sda_oe_n_o                 (dev_sda_oe_n),
		.pin_gain_code_i            (pin_code),
		.dp_sink_sel_i              (dp_sel),
		.train_level_i              (lvl),
		.hbr2_rate_i                (rate2),
		.lane_gain_code_o           (code_o),
		.lane_boost_tenth_db_o      (boost_o),
		.register_gain_control_on_o (reg_on),
		.link_training_on_o         (train_on)
	);

	i2c_host_model u_host (
		.clk_sys_i      (clk_sys_i),
		.dev_sda_i      (dev_sda),
		.dev_sda_oe_n_i (dev_sda_oe_n),
		.scl_o          (scl),
		.sda_line_o     (sda_line)
	);

	// ---------------------------------------------------------------
	// comparison and verdict
	// ---------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// applied code from the image: pins, fixed level 1, or trained level
	function automatic logic [2:0] exp_code(input int lane, input logic trn);
		logic [7:0] lo;
		logic [7:0] hi;
		lo = shadow[5 + 2 * lane];
		hi = (lane < 2) ? shadow[6 + 2 * lane] : 8'h00; // lane 2 upper not held
		if (!shadow[5][7]) return pin_code;
		if (!dp_sel || !trn) return lo[2:0];
		case (lvl)
			2'h0: return lo[6:4];
			2'h1: return lo[2:0];
			2'h2: return hi[6:4];
			default: return hi[2:0];
		endcase
	endfunction

	// drive each of 16 sweep points, let the pin filter settle, check all lanes
	task automatic sweep(input logic trn);
		logic [2:0] c;
		for (int k = 0; k < 16; k++) begin
			@(posedge clk_sys_i);
			#10;
			{dp_sel, lvl, rate2} = k[3:0];
			pin_code = 3'($urandom);
			repeat (6) @(posedge clk_sys_i);
			#10;
			for (int l = 0; l < 3; l++) begin
				c = exp_code(l, trn);
				check({5'h00, code_o[l]}, {5'h00, c});
				check(boost_o[l], rate2 ? HBR2_T[c] : HBR_T[c]);
			end
		end
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(48443));
		repeat (2) @(posedge clk_sys_i);
		#10;
		rstn_i = 1'b1;
		repeat (6) @(posedge clk_sys_i);
		#10;
		check({7'h00, reg_on}, 8'h00);
		check({7'h00, train_on}, 8'h01);
		for (int l = 0; l < 3; l++) check({5'h00, code_o[l]}, 8'h00);
		u_host.read_regs(8'h04, 6, d, nak);
		check({7'h00, nak}, 8'h00);
		for (int i = 0; i < 6; i++) check(d[i], (i == 0) ? 8'h04 : 8'h00);
		// a wrong device address must be left unanswered
		u_host.start();
		u_host.send_byte({eq_sel_pkg::DEV_ADDR ^ 7'h01, 1'b0}, nak);
		u_host.stop();
		check({7'h00, nak}, 8'h01);
		for (int r = 0; r < 3; r++) begin
			// random contents with reserved bits set; round 0 keeps pins in charge
			for (int i = 0; i < 5; i++) d[i] = 8'($urandom) | 8'h88;
			if (r == 0) d[0][7] = 1'b0;
			u_host.write_regs(8'h05, d, 5, nak);
			check({7'h00, nak}, 8'h00);
			shadow[5] = d[0] & 8'hf7;
			for (int i = 1; i < 5; i++) shadow[5 + i] = d[i] & 8'h77;
			shadow[10] = 8'h00;
			u_host.read_regs(8'h05, 6, d, nak);
			for (int i = 0; i < 6; i++) check(d[i], shadow[5 + i]);
			check({7'h00, reg_on}, {7'h00, shadow[5][7]});
			for (int t = 0; t < 2; t++) begin
				d[0] = (t == 1) ? 8'h04 : 8'hfb; // only the enable bit is kept
				u_host.write_regs(8'h04, d, 1, nak);
				repeat (3) @(posedge clk_sys_i);
				#10;
				check({7'h00, train_on}, t[7:0]);
				sweep(t[0]);
			end
		end
		final_report();
	end

	// ---------------------------------------------------------------
	// watchdog: the full run needs about 15k cycles
	// ---------------------------------------------------------------
	initial begin
		repeat (80000) @(posedge clk_sys_i);
		err_count++;
		final_report();
	end
endmodule
